// file: hw/gcrsg_top.sv
/*
 * General call software reset detector, converter supply gate and result hold.
 * Assumes scl/sda arrive asynchronously from pins; conversion inputs and alarm
 * requests come from logic on core_clk.
 */
`timescale 1ns/100ps
module gcrsg_top
    import gcrsg_pkg::*;
(
    input  wire logic              core_clk,
    input  wire logic              reset_n,
    input  wire logic              sclIn,
    input  wire logic              sdaIn,
    output logic                   sdaOut,
    output logic                   sdaOe,
    input  wire logic              supplyValid,
    input  gcrsg_conv_s            convIn,
    input  wire logic              limitWarnReq,
    input  wire logic              overTempReq,
    output logic                   convEnable,
    output logic                   convAbort,
    output logic [TEMP_W-1:0]      tempResult,
    output logic                   softReset,
    output logic                   limitWarnOut,
    output logic                   limitWarnOe,
    output logic                   overTempOut,
    output logic                   overTempOe
);

    typedef struct packed {
        logic [1:0]        sclSync;
        logic [1:0]        sdaSync;
        logic [1:0]        supSync;
        logic              sclPrev;
        logic              sdaPrev;
        gcrsg_bus_e        bus;
        logic [3:0]        bitCnt;
        logic [7:0]        shift;
        logic              ackDrive;
        logic              isReset;
        gcrsg_conv_e       conv;
        logic              abort;
        logic [TEMP_W-1:0] temp;
        logic              warn;
        logic              over;
    } gcrsg_state_s;

    gcrsg_state_s st_q;
    gcrsg_state_s st_d;

    logic scl;
    logic sda;
    logic sup;
    logic startCond;
    logic stopCond;
    logic sclRise;
    logic sclFall;

    assign scl       = st_q.sclSync[1];
    assign sda       = st_q.sdaSync[1];
    assign sup       = st_q.supSync[1];
    assign startCond = scl && st_q.sclPrev && st_q.sdaPrev && !sda;
    assign stopCond  = scl && st_q.sclPrev && !st_q.sdaPrev && sda;
    assign sclRise   = scl && !st_q.sclPrev;
    assign sclFall   = !scl && st_q.sclPrev;

    always_comb begin
        st_d         = st_q;
        st_d.sclSync = {st_q.sclSync[0], sclIn};
        st_d.sdaSync = {st_q.sdaSync[0], sdaIn};
        st_d.supSync = {st_q.supSync[0], supplyValid};
        st_d.sclPrev = scl;
        st_d.sdaPrev = sda;
        st_d.isReset = 1'b0;
        st_d.abort   = 1'b0;

        // ------------------------------------------------------------
        // Two-wire receiver: only the general call is of interest here
        // ------------------------------------------------------------
        if (startCond) begin
            st_d.bus      = GC_ADDR;
            st_d.bitCnt   = '0;
            st_d.ackDrive = 1'b0;
        end else if (stopCond) begin
            st_d.bus      = GC_IDLE;
            st_d.ackDrive = 1'b0;
        end else begin
            case (st_q.bus)
                GC_ADDR, GC_DATA: begin
                    if (sclRise && st_q.bitCnt < BITS_PER_BYTE) begin
                        st_d.shift  = {st_q.shift[6:0], sda};
                        st_d.bitCnt = st_q.bitCnt + 4'h1;
                    end
                    if (sclFall && st_q.bitCnt == BITS_PER_BYTE) begin
                        if (st_q.bus == GC_ADDR) begin
                            // Only a general call write is acknowledged
                            if (st_q.shift == {GEN_CALL_ADDR, 1'b0}) begin
                                st_d.ackDrive = 1'b1; // R01
                                st_d.bitCnt   = ACK_SLOT;
                            end else begin
                                st_d.bus = GC_SKIP;
                            end
                        end else begin
                            st_d.ackDrive = 1'b1;
                            st_d.bitCnt   = ACK_SLOT;
                            if (st_q.shift == SOFT_RESET_CMD) begin
                                st_d.isReset = 1'b1; // R02
                            end
                            // Other codes take no action // R06
                        end
                    end else if (sclFall && st_q.bitCnt == ACK_SLOT) begin
                        st_d.ackDrive = 1'b0;
                        st_d.bitCnt   = '0;
                        st_d.bus      = (st_q.bus == GC_ADDR) ? GC_DATA : GC_SKIP;
                    end
                end
                GC_SKIP: st_d.bus = GC_SKIP;
                default: st_d.bus = GC_IDLE;
            endcase
        end

        // ------------------------------------------------------------
        // Conversion sequencer with supply gate
        // ------------------------------------------------------------
        case (st_q.conv)
            CV_IDLE: begin
                if (convIn.start && sup) begin // R09
                    st_d.conv = CV_RUN;
                end
            end
            CV_RUN: begin
                if (!sup) begin
                    // Dropout mid-conversion discards the sample // R08
                    st_d.conv  = CV_IDLE;
                    st_d.abort = 1'b1;
                end else if (convIn.done) begin
                    st_d.temp = convIn.sample; // R10
                    st_d.conv = CV_IDLE;
                end
            end
            default: st_d.conv = CV_IDLE;
        endcase

        st_d.warn = limitWarnReq;
        st_d.over = overTempReq;

        // ------------------------------------------------------------
        // Software reset: registers, conversion and alarms back to power-on
        // ------------------------------------------------------------
        if (st_q.isReset) begin
            st_d.temp     = TEMP_RESET; // R03
            st_d.abort    = (st_q.conv == CV_RUN); // R04
            st_d.conv     = CV_IDLE; // R04
            st_d.warn     = 1'b0; // R05
            st_d.over     = 1'b0; // R05
            // Ack still driven in this cycle and released here; rest of frame ignored
            st_d.bus      = startCond ? GC_ADDR : GC_IDLE; // R11
            st_d.ackDrive = 1'b0;
        end
    end

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            st_q         <= '0;
            st_q.sclSync <= 2'b11;
            st_q.sdaSync <= 2'b11;
            st_q.sclPrev <= 1'b1;
            st_q.sdaPrev <= 1'b1;
            st_q.bus     <= GC_IDLE;
            st_q.conv    <= CV_IDLE;
            st_q.temp    <= TEMP_RESET;
        end else begin
            st_q <= st_d;
        end
    end

    assign sdaOut       = 1'b0;
    assign sdaOe        = st_q.ackDrive;
    // Supply drop cuts the enable at once, not at conversion end
    assign convEnable   = sup && (st_q.conv == CV_RUN); // R07
    assign convAbort    = st_q.abort;
    assign tempResult   = st_q.temp;
    assign softReset    = st_q.isReset;
    assign limitWarnOut = 1'b0;
    assign limitWarnOe  = st_q.warn;
    assign overTempOut  = 1'b0;
    assign overTempOe   = st_q.over;

endmodule : gcrsg_top

// file: hw/gcrsg_pkg.sv
/*
 * Shared constants and carrier types for the general call reset and supply gate.
 * Assumes a single 125 MHz core clock and the two-wire pins sampled inside the block.
 */
// Contract
// (R01) Acknowledge general call address 00h, then receive and evaluate the next byte.
// (R02) A second byte of 06h triggers software reset; master must send it second.
// (R03) Software reset returns every register to its power-on value.
// (R04) Software reset abandons any running conversion without producing a result.
// (R05) Software reset releases both alarm outputs to inactive high.
// (R06) Any other second byte changes no register, conversion or output.
// (R07) Converter is enabled only while supply-valid is asserted.
// (R08) Supply-valid is sampled continuously throughout every conversion.
// (R09) No conversion is carried out while supply-valid is low.
// (R10) Skipped or invalidated conversions leave the result registers unchanged.
// (R11) After software reset the serial port idles until the next START.
package gcrsg_pkg;

    // ------------------------------------------------------------
    // Bus codes
    // ------------------------------------------------------------
    localparam logic [6:0] GEN_CALL_ADDR  = 7'h00;
    localparam logic [7:0] SOFT_RESET_CMD = 8'h06;
    localparam logic [3:0] BITS_PER_BYTE  = 4'h8;
    localparam logic [3:0] ACK_SLOT       = 4'h9;

    // ------------------------------------------------------------
    // Result width and reset value
    // ------------------------------------------------------------
    localparam int         TEMP_W     = 12;
    localparam logic [TEMP_W-1:0] TEMP_RESET = 12'h000;

    typedef enum logic [3:0] {
        GC_IDLE = 4'b0001,
        GC_ADDR = 4'b0010,
        GC_DATA = 4'b0100,
        GC_SKIP = 4'b1000
    } gcrsg_bus_e;

    typedef enum logic [1:0] {
        CV_IDLE = 2'b01,
        CV_RUN  = 2'b10
    } gcrsg_conv_e;

    // Conversion request and finished measurement from the analog side
    typedef struct packed {
        logic              start;
        logic              done;
        logic [TEMP_W-1:0] sample;
    } gcrsg_conv_s;

endpackage : gcrsg_pkg

// file: test/gcrsg_checker.sv
/* Port assertions for the general call reset and supply gate.
   Assumes one core clock domain; bound in at the foot. */
`timescale 1ns/100ps
module gcrsg_checker
    import gcrsg_pkg::*;
(
    input wire logic              core_clk,
    input wire logic              reset_n,
    input wire logic              supplyValid,
    input gcrsg_conv_s            convIn,
    input wire logic              convEnable,
    input wire logic              convAbort,
    input wire logic [TEMP_W-1:0] tempResult,
    input wire logic              softReset,
    input wire logic              sdaOe,
    input wire logic              limitWarnOe,
    input wire logic              overTempOe
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!reset_n);
    // --------
    // Gate
    // --------
    supply_gate_a: assert property (
        convEnable |-> $past(supplyValid, 2)) else $error("converter on without supply");
    drop_abort_a: assert property (
        convEnable && !supplyValid && !convIn.done |-> ##[1:4] convAbort) else $error("no abort on drop");
    result_hold_a: assert property (
        $changed(tempResult) |-> $past(convIn.done) || $past(softReset)) else $error("result moved");
    // --------
    // Reset
    // --------
    reset_ack_a: assert property (
        softReset |-> sdaOe) else $error("reset without ack");
    regs_cleared_a: assert property (
        softReset |=> tempResult == TEMP_RESET) else $error("result not cleared");
    conv_abandon_a: assert property (
        softReset && convEnable |=> convAbort) else $error("conversion kept");
    alarms_release_a: assert property (
        softReset |=> !limitWarnOe && !overTempOe) else $error("alarm held");
    port_idle_a: assert property (
        softReset |=> !sdaOe ##1 !softReset) else $error("port not idle");
    cover property (softReset);
    cover property (convAbort);
    cover property (convIn.done && convEnable);
endmodule : gcrsg_checker
bind gcrsg_top gcrsg_checker chk (.core_clk(core_clk), .reset_n(reset_n), .supplyValid(supplyValid),
    .convIn(convIn), .convEnable(convEnable), .convAbort(convAbort), .tempResult(tempResult),
    .softReset(softReset), .sdaOe(sdaOe), .limitWarnOe(limitWarnOe), .overTempOe(overTempOe));

// file: test/gcrsg_master.sv
/* Two-wire bus master model sending general call frames.
   Assumes the bench forms the pulled-up SDA level. */
`timescale 1ns/100ps
module gcrsg_master (
    input  wire logic core_clk,
    input  wire logic sdaLine,
    output logic      scl,
    output logic      sdaDrv
);
    int hp = 8;  // SCL half period in clocks; raise for a slow master
    initial begin
        scl = 1'b1;
        sdaDrv = 1'b1;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge core_clk);
    endtask : tick
    task automatic startBit;
        sdaDrv <= 1'b1;
        tick(2);
        scl <= 1'b1;
        tick(hp);
        sdaDrv <= 1'b0;
        tick(hp);
        scl <= 1'b0;
        tick(2);
    endtask : startBit
    task automatic stopBit;
        sdaDrv <= 1'b0;
        tick(hp);
        scl <= 1'b1;
        tick(hp);
        sdaDrv <= 1'b1;
        tick(hp);
    endtask : stopBit
    task automatic sendByte(input logic [7:0] b, output logic ack);
        for (int i = 7; i >= 0; i--) begin
            sdaDrv <= b[i];
            tick(hp);
            scl <= 1'b1;
            tick(hp);
            scl <= 1'b0;
            tick(2);
        end
        sdaDrv <= 1'b1;
        ack = 1'b0;
        // A reset ack lasts one clock, so the whole slot is watched
        for (int i = 0; i < 2 * hp; i++) begin
            tick(1);
            if (sdaLine === 1'b0) ack = 1'b1;
            if (i == hp) scl <= 1'b1;
        end
        scl <= 1'b0;
        tick(2);
    endtask : sendByte
endmodule : gcrsg_master

// file: test/gcrsg_top_bench.sv
/* Bench for the general call reset and supply gate.
   Assumes the checker is bound in and SDA is pulled up. */
`timescale 1ns/100ps
module gcrsg_top_bench;
    import gcrsg_pkg::*;
    logic core_clk, reset_n, supplyValid, limitWarnReq, overTempReq, ack;
    logic sdaOe, convEnable, convAbort, softReset, limitWarnOe, overTempOe;
    logic sdaOut, limitWarnOut, overTempOut;
    logic [TEMP_W-1:0] tempResult;
    gcrsg_conv_s convIn;
    wire logic scl, mSda, sdaLine;
    int err_count, comparisons, cycles, rstSeen, abortSeen;
    assign sdaLine = mSda & !sdaOe;
    gcrsg_master master (.core_clk(core_clk), .sdaLine(sdaLine), .scl(scl), .sdaDrv(mSda));
    gcrsg_top DUT (.core_clk(core_clk), .reset_n(reset_n), .sclIn(scl), .sdaIn(sdaLine), .sdaOut(sdaOut),
        .sdaOe(sdaOe), .supplyValid(supplyValid), .convIn(convIn), .limitWarnReq(limitWarnReq),
        .overTempReq(overTempReq), .convEnable(convEnable), .convAbort(convAbort),
        .tempResult(tempResult), .softReset(softReset), .limitWarnOut(limitWarnOut),
        .limitWarnOe(limitWarnOe), .overTempOut(overTempOut), .overTempOe(overTempOe));
    initial begin
        core_clk = 1'b0;
        forever #4 core_clk = ~core_clk;
    end
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp) begin
            err_count++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic end_of_test;
        if (err_count == 0 && comparisons > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : end_of_test
    task automatic convert(input logic [TEMP_W-1:0] s, input logic fin);
        convIn.start <= 1'b1;
        master.tick(1);
        convIn.start <= 1'b0;
        master.tick(3);
        check("convEnable", convEnable, supplyValid);
        convIn.done <= fin;
        convIn.sample <= s;
        master.tick(1);
        convIn.done <= 1'b0;
        master.tick(3);
    endtask : convert
    always @(posedge core_clk) begin
        cycles++;
        rstSeen += (softReset === 1'b1);
        abortSeen += (convAbort === 1'b1);
        if (cycles == 20000) begin
            err_count++;
            end_of_test();
        end
    end
    task automatic supplyGateTest;
        convert(12'h5a3, 1'b1);
        check("result", tempResult, 12'h5a3);
        supplyValid <= 1'b0;
        master.tick(4);
        convert(12'h0ff, 1'b1);
        check("skipped result", tempResult, 12'h5a3);
        supplyValid <= 1'b1;
        master.tick(4);
        convert(12'h111, 1'b0);
        supplyValid <= 1'b0;
        master.tick(6);
        check("drop abort", abortSeen, 1);
        check("dropped result", tempResult, 12'h5a3);
        supplyValid <= 1'b1;
        master.tick(4);
    endtask : supplyGateTest
    // Reset code behind a read call or a foreign address must not act
    task automatic refusedTest;
        master.hp = 20;
        master.startBit();
        master.sendByte(8'h01, ack);
        check("read call ack", ack, 0);
        master.sendByte(SOFT_RESET_CMD, ack);
        check("skipped byte ack", ack, 0);
        master.stopBit();
        master.startBit();
        master.sendByte(8'h98, ack);
        check("other address ack", ack, 0);
        master.sendByte(SOFT_RESET_CMD, ack);
        master.stopBit();
        check("no reset", rstSeen, 0);
    endtask : refusedTest
    task automatic otherByteTest;
        limitWarnReq <= 1'b1;
        master.startBit();
        master.sendByte(8'h00, ack);
        check("address ack", ack, 1);
        master.sendByte(8'h55, ack);
        check("data ack", ack, 1);
        master.stopBit();
        check("other byte", rstSeen, 0);
        check("alarm kept", limitWarnOe, 1);
        check("result kept", tempResult, 12'h5a3);
        check("no abort", abortSeen, 1);
        master.hp = 8;
    endtask : otherByteTest
    task automatic softResetTest;
        overTempReq <= 1'b1;
        convert(12'h222, 1'b0);
        check("alarm raised", overTempOe, 1);
        master.startBit();
        master.sendByte(8'h00, ack);
        master.sendByte(SOFT_RESET_CMD, ack);
        check("reset ack", ack, 1);
        check("reset seen", rstSeen, 1);
        check("cleared", tempResult, TEMP_RESET);
        check("abandoned", abortSeen, 2);
        master.sendByte(8'h00, ack);
        check("idle port", ack, 0);
        master.stopBit();
        check("sda level", sdaOut, 0);
        check("warn level", limitWarnOut, 0);
        check("over level", overTempOut, 0);
    endtask : softResetTest
    initial begin
        {reset_n, limitWarnReq, overTempReq} = 3'h0;
        supplyValid = 1'b1;
        convIn = '0;
        master.tick(4);
        reset_n <= 1'b1;
        master.tick(3);
        supplyGateTest();
        refusedTest();
        otherByteTest();
        softResetTest();
        end_of_test();
    end
endmodule : gcrsg_top_bench
